// file: qpv_pkg.sv
// Shared constants and types for the quadrature position and velocity decoder
`default_nettype none
package qpv_pkg;
    // Data path widths
    localparam int POS_W = 16;
    localparam int ADDR_W = 8;
    localparam int PSC_W = 6;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POS = 8'h04;
    localparam logic [7:0] OFS_MAX = 8'h08;
    localparam logic [7:0] OFS_VEL = 8'h0C;
    localparam logic [7:0] OFS_TMR = 8'h10;
    localparam logic [7:0] OFS_FLAG = 8'h14;
    // Control register field positions
    localparam int CTL_DEC_LSB = 0;
    localparam int CTL_MODE_LSB = 2;
    localparam int CTL_DIR_BIT = 5;
    localparam int CTL_ERR_BIT = 6;
    localparam int CTL_VDIS_BIT = 7;
    localparam int CTL_CREN_BIT = 8;
    localparam int CTL_ICEN_BIT = 9;
    // Event flag register bit positions
    localparam int FLG_VEL_BIT = 0;
    localparam int FLG_POS_BIT = 1;
    localparam int FLG_DIR_BIT = 2;
    // Reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [1:0] DEC_RST = 2'h0;
    localparam logic [15:0] WORD_RST = 16'h0000;
    // Decoder mode codes
    typedef enum logic [2:0] {
        QPV_OFF = 3'h0,
        QPV_X2_IDX = 3'h1,
        QPV_X2_PER = 3'h2,
        QPV_X4_IDX = 3'h5,
        QPV_X4_PER = 3'h6
    } qpv_mode_t;
    // Postscaler terminal counts for 1:1, 1:4, 1:16, 1:64
    localparam logic [5:0] PSC_LAST_1 = 6'h00;
    localparam logic [5:0] PSC_LAST_4 = 6'h03;
    localparam logic [5:0] PSC_LAST_16 = 6'h0F;
    localparam logic [5:0] PSC_LAST_64 = 6'h3F;
endpackage
`default_nettype wire

// file: qpv_sync.sv
// Two-flop synchroniser bank for the encoder inputs
`timescale 1ns/1ps
`default_nettype none
module qpv_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk, // Sampling clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] d, // Raw asynchronous inputs
    output logic [WIDTH-1:0] q // Synchronised outputs
);
    // One pair of flops per input; the first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_r;
            logic sync_r;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= d[g];
                    sync_r <= meta_r;
                end
            end
            assign q[g] = sync_r;
        end
    endgenerate
endmodule
`default_nettype wire

// file: qpv_decoder.sv
// Quadrature position and velocity decoder with APB register access
//
// Overview of operation
// - Mode zero switches off all position counting and velocity pulses.
// - Two-times modes count both edges of phase A only.
// - Four-times modes count both edges of phase A and phase B.
// - Modes 1 and 5 reset by index; 2 and 6 by period match.
// - Direction bit is 1 and counter increments when A leads B.
// - Each counted edge picks up or down from the A/B phase relation.
// - Index mode forward: rising index clears counter on next phase edge.
// - Index mode reverse: falling index loads max count on next phase edge.
// - Period mode forward: counter at max clears on next edge, event after.
// - Period mode reverse: counter at zero loads max, event one cycle after.
// - Changing or clearing the mode never alters the position counter.
// - Position event on period match, period-mode wrap, and index detection.
// - Direction change sets its flag two clocks after the edge is seen.
// - A counter wrap in index mode sets the error bit.
// - Position event pulse lasts one clock; flag stays until cleared.
// - Velocity active only with disable bit low and a valid mode.
// - Velocity events on phase A edges, or A and B in four-times.
// - Postscaler divides velocity events by 1, 4, 16 or 64.
// - Postscaler output captures the timer, then restarts from zero.
// - With reset enable set, capture clears the timer next cycle.
// - Entering velocity mode keeps timer value and postscaler setting.
// - Velocity flag sets whenever the velocity register updates.
// - Error bit is cleared only by software.
// - Decoder enabled forces the capture channel off.
`timescale 1ns/1ps
`default_nettype none
module qpv_decoder #(
    parameter int W = qpv_pkg::POS_W
) (
    input wire logic pclk, // Bus and decoder clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [qpv_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic phase_a_input, // Encoder phase A
    input wire logic phase_b_input, // Encoder phase B
    input wire logic index_input, // Encoder index
    output logic position_event_flag, // Sticky position event
    output logic direction_change_flag, // Sticky direction change
    output logic velocity_event_flag, // Sticky velocity update
    output logic counter_error_bit, // Sticky wrap error
    output logic capture_channel_active // Capture channel allowed to run
);
    logic [2:0] mode_r;
    logic [1:0] dec_r;
    logic vel_dis_r, cren_r, ic_en_r, dir_r, err_r;
    logic [W-1:0] pos_r, max_r, velocity_register_r, tmr_r, pos_nxt;
    logic pos_flag_r, dir_flag_r, vel_flag_r;
    logic pos_evt_r, reload_r, dir_chg_r, tmr_clr_r, fwd_pend_r, rev_pend_r;
    logic a_d_r, b_d_r, i_d_r, pready_r, pslverr_r;
    logic [31:0] prdata_r, rd_val;
    logic [qpv_pkg::PSC_W-1:0] psc_r, psc_last;
    logic [2:0] sync_q;
    logic qa, qb, qi, a_edge, b_edge, idx_rise, idx_fall;
    logic on, is_x4, idx_mode, per_mode, cnt_edge, dir_edge, up_now;
    logic reset_evt, wrap_idx, vel_on, vel_cap, addr_ok;
    logic wr_acc, ctrl_wr, pos_wr, max_wr, tmr_wr, flag_wr;

    // Inputs cross into the clock domain before any edge logic
    qpv_sync #(.WIDTH(3)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({index_input, phase_b_input, phase_a_input}),
        .q(sync_q)
    );
    assign qa = sync_q[0];
    assign qb = sync_q[1];
    assign qi = sync_q[2];

    // Previous samples for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_d_r <= 1'b0;
            b_d_r <= 1'b0;
            i_d_r <= 1'b0;
        end else begin
            a_d_r <= qa;
            b_d_r <= qb;
            i_d_r <= qi;
        end
    end

    // Edge and mode decode
    assign a_edge = qa ^ a_d_r;
    assign b_edge = qb ^ b_d_r;
    assign idx_rise = qi & ~i_d_r;
    assign idx_fall = ~qi & i_d_r;
    assign is_x4 = (mode_r == qpv_pkg::QPV_X4_IDX) || (mode_r == qpv_pkg::QPV_X4_PER);
    assign idx_mode = (mode_r == qpv_pkg::QPV_X2_IDX) || (mode_r == qpv_pkg::QPV_X4_IDX);
    assign per_mode = (mode_r == qpv_pkg::QPV_X2_PER) || (mode_r == qpv_pkg::QPV_X4_PER);
    assign on = idx_mode | per_mode;
    // Unused codes behave as off, so no stray counting
    assign cnt_edge = on & (a_edge | (is_x4 & b_edge));
    assign dir_edge = on & (a_edge | b_edge);
    // A edge with A!=B, or B edge with A==B, is the forward sequence
    assign up_now = a_edge ? (qa ^ qb) : ~(qa ^ qb);

    // Bus decode; writes land at the access edge
    assign wr_acc = psel & penable & pwrite & pready_r;
    assign ctrl_wr = wr_acc && (paddr == qpv_pkg::OFS_CTRL);
    assign pos_wr = wr_acc && (paddr == qpv_pkg::OFS_POS);
    assign max_wr = wr_acc && (paddr == qpv_pkg::OFS_MAX);
    assign tmr_wr = wr_acc && (paddr == qpv_pkg::OFS_TMR);
    assign flag_wr = wr_acc && (paddr == qpv_pkg::OFS_FLAG);
    assign addr_ok = (paddr == qpv_pkg::OFS_CTRL) || (paddr == qpv_pkg::OFS_POS)
        || (paddr == qpv_pkg::OFS_MAX) || (paddr == qpv_pkg::OFS_VEL)
        || (paddr == qpv_pkg::OFS_TMR) || (paddr == qpv_pkg::OFS_FLAG);

    // Next position; reloads report an event, index-mode wraps an error
    always_comb begin
        pos_nxt = pos_r;
        reset_evt = 1'b0;
        wrap_idx = 1'b0;
        if (cnt_edge) begin
            if (up_now) begin
                if (idx_mode && fwd_pend_r) begin
                    pos_nxt = '0;
                    reset_evt = 1'b1;
                end else if (per_mode && pos_r == max_r) begin
                    pos_nxt = '0;
                    reset_evt = 1'b1;
                end else begin
                    pos_nxt = pos_r + W'(1);
                    reset_evt = per_mode && (&pos_r);
                    wrap_idx = idx_mode && (&pos_r);
                end
            end else begin
                if (idx_mode && rev_pend_r) begin
                    pos_nxt = max_r;
                    reset_evt = 1'b1;
                end else if (per_mode && pos_r == '0) begin
                    pos_nxt = max_r;
                    reset_evt = 1'b1;
                end else begin
                    pos_nxt = pos_r - W'(1);
                    wrap_idx = idx_mode && (pos_r == '0);
                end
            end
        end
    end

    // Position counter; mode writes never touch it, software write wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_r <= qpv_pkg::WORD_RST;
        end else if (pos_wr) begin
            pos_r <= pwdata[W-1:0];
        end else begin
            pos_r <= pos_nxt;
        end
    end

    // Index arming; a new index edge beats consumption in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_pend_r <= 1'b0;
            rev_pend_r <= 1'b0;
        end else if (!idx_mode) begin
            fwd_pend_r <= 1'b0;
            rev_pend_r <= 1'b0;
        end else begin
            fwd_pend_r <= idx_rise | (fwd_pend_r & ~(cnt_edge & up_now));
            rev_pend_r <= idx_fall | (rev_pend_r & ~(cnt_edge & ~up_now));
        end
    end

    // Direction tracking and change detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r <= 1'b0;
            dir_chg_r <= 1'b0;
        end else begin
            dir_chg_r <= dir_edge & (up_now != dir_r);
            if (dir_edge) begin
                dir_r <= up_now;
            end
        end
    end

    // One-cycle position event; an extra stage makes it trail the reload by a cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_r <= 1'b0;
            pos_evt_r <= 1'b0;
        end else begin
            reload_r <= reset_evt;
            pos_evt_r <= reload_r;
        end
    end

    // Sticky flags; hardware set wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_flag_r <= 1'b0;
            dir_flag_r <= 1'b0;
            vel_flag_r <= 1'b0;
        end else begin
            pos_flag_r <= pos_evt_r
                | (pos_flag_r & ~(flag_wr & pwdata[qpv_pkg::FLG_POS_BIT]));
            dir_flag_r <= dir_chg_r
                | (dir_flag_r & ~(flag_wr & pwdata[qpv_pkg::FLG_DIR_BIT]));
            vel_flag_r <= vel_cap
                | (vel_flag_r & ~(flag_wr & pwdata[qpv_pkg::FLG_VEL_BIT]));
        end
    end

    // Error bit: set by index-mode wrap, cleared only by writing zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_r <= 1'b0;
        end else begin
            err_r <= wrap_idx
                | (err_r & ~(ctrl_wr & ~pwdata[qpv_pkg::CTL_ERR_BIT]));
        end
    end

    // Control fields; decimation survives velocity disable so it is reused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= qpv_pkg::MODE_RST;
            dec_r <= qpv_pkg::DEC_RST;
            vel_dis_r <= 1'b0;
            cren_r <= 1'b0;
            ic_en_r <= 1'b0;
        end else if (ctrl_wr) begin
            mode_r <= pwdata[qpv_pkg::CTL_MODE_LSB +: 3];
            dec_r <= pwdata[qpv_pkg::CTL_DEC_LSB +: 2];
            vel_dis_r <= pwdata[qpv_pkg::CTL_VDIS_BIT];
            cren_r <= pwdata[qpv_pkg::CTL_CREN_BIT];
            ic_en_r <= pwdata[qpv_pkg::CTL_ICEN_BIT];
        end
    end

    // Maximum count limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            max_r <= qpv_pkg::WORD_RST;
        end else if (max_wr) begin
            max_r <= pwdata[W-1:0];
        end
    end

    // Velocity postscaler
    assign vel_on = on & ~vel_dis_r;
    always_comb begin
        case (dec_r)
            2'h0: psc_last = qpv_pkg::PSC_LAST_1;
            2'h1: psc_last = qpv_pkg::PSC_LAST_4;
            2'h2: psc_last = qpv_pkg::PSC_LAST_16;
            default: psc_last = qpv_pkg::PSC_LAST_64;
        endcase
    end
    assign vel_cap = vel_on & cnt_edge & (psc_r == psc_last);

    // Count restarts from zero after every capture and while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_r <= '0;
        end else if (!vel_on || vel_cap) begin
            psc_r <= '0;
        end else if (cnt_edge) begin
            psc_r <= psc_r + qpv_pkg::PSC_W'(1);
        end
    end

    // Velocity register takes the timer on each postscaler output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            velocity_register_r <= qpv_pkg::WORD_RST;
            tmr_clr_r <= 1'b0;
        end else begin
            tmr_clr_r <= vel_cap & cren_r;
            if (vel_cap) begin
                velocity_register_r <= tmr_r;
            end
        end
    end

    // Shared time base; enabling velocity mode leaves it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_r <= qpv_pkg::WORD_RST;
        end else if (tmr_wr) begin
            tmr_r <= pwdata[W-1:0];
        end else if (tmr_clr_r) begin
            tmr_r <= '0;
        end else begin
            tmr_r <= tmr_r + W'(1);
        end
    end

    // Read mux
    always_comb begin
        rd_val = 32'h00000000;
        case (paddr)
            qpv_pkg::OFS_CTRL: begin
                rd_val[qpv_pkg::CTL_DEC_LSB +: 2] = dec_r;
                rd_val[qpv_pkg::CTL_MODE_LSB +: 3] = mode_r;
                rd_val[qpv_pkg::CTL_DIR_BIT] = dir_r;
                rd_val[qpv_pkg::CTL_ERR_BIT] = err_r;
                rd_val[qpv_pkg::CTL_VDIS_BIT] = vel_dis_r;
                rd_val[qpv_pkg::CTL_CREN_BIT] = cren_r;
                rd_val[qpv_pkg::CTL_ICEN_BIT] = ic_en_r;
            end
            qpv_pkg::OFS_POS: rd_val[W-1:0] = pos_r;
            qpv_pkg::OFS_MAX: rd_val[W-1:0] = max_r;
            qpv_pkg::OFS_VEL: rd_val[W-1:0] = velocity_register_r;
            qpv_pkg::OFS_TMR: rd_val[W-1:0] = tmr_r;
            qpv_pkg::OFS_FLAG: begin
                rd_val[qpv_pkg::FLG_VEL_BIT] = vel_flag_r;
                rd_val[qpv_pkg::FLG_POS_BIT] = pos_flag_r;
                rd_val[qpv_pkg::FLG_DIR_BIT] = dir_flag_r;
            end
            default: rd_val = 32'h00000000;
        endcase
    end

    // APB answer: sampled in setup, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= psel & ~penable;
            pslverr_r <= psel & ~penable & ~addr_ok;
            if (psel && !penable && !pwrite) begin
                prdata_r <= rd_val;
            end
        end
    end

    // Capture channel runs only while the decoder is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_channel_active <= 1'b0;
        end else begin
            capture_channel_active <= ic_en_r & ~on;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign position_event_flag = pos_flag_r;
    assign direction_change_flag = dir_flag_r;
    assign velocity_event_flag = vel_flag_r;
    assign counter_error_bit = err_r;

    // Checks on the decoder behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_off_pos_hold: assert property (!on && !pos_wr |=> $stable(pos_r))
        else $error("position moved while decoder off");
    a_x2_b_ignored: assert property ((on && !is_x4 && b_edge && !a_edge && !pos_wr)
        |=> $stable(pos_r))
        else $error("phase B edge counted in x2 mode");
    a_x4_b_counts: assert property ((mode_r == qpv_pkg::QPV_X4_PER && b_edge && !a_edge
        && up_now && pos_r != max_r && !(&pos_r) && !pos_wr)
        |=> pos_r == $past(pos_r) + W'(1))
        else $error("phase B edge not counted up in x4 mode");
    a_dir_follow: assert property (dir_edge |=> dir_r == $past(up_now))
        else $error("direction bit does not follow phase relation");
    a_idx_fwd_zero: assert property ((idx_mode && fwd_pend_r && cnt_edge && up_now && !pos_wr)
        |=> pos_r == '0 ##1 pos_evt_r)
        else $error("index forward reset missed");
    a_idx_rev_load: assert property ((idx_mode && rev_pend_r && cnt_edge && !up_now && !pos_wr)
        |=> pos_r == $past(max_r))
        else $error("index reverse load missed");
    a_per_match: assert property ((per_mode && cnt_edge && up_now && pos_r == max_r && !pos_wr)
        |=> pos_r == '0 ##1 pos_evt_r ##1 pos_flag_r)
        else $error("period match reset or event missed");
    a_per_under: assert property ((per_mode && cnt_edge && !up_now && pos_r == '0 && !pos_wr)
        |=> pos_r == $past(max_r) ##1 pos_evt_r)
        else $error("period underflow load or event missed");
    a_dir_flag: assert property ((dir_edge && up_now != dir_r) |=> ##1 dir_flag_r)
        else $error("direction change flag late");
    a_err_sticky: assert property ((err_r && !ctrl_wr) |=> err_r)
        else $error("error bit cleared by hardware");
    a_idx_wrap_err: assert property (wrap_idx |=> err_r)
        else $error("index mode wrap did not set error");
    a_vel_capture: assert property (vel_cap |=> velocity_register_r == $past(tmr_r) && vel_flag_r
        && psc_r == '0)
        else $error("velocity capture incomplete");
    a_vel_off: assert property (!vel_on |-> !vel_cap ##1 psc_r == '0)
        else $error("velocity activity while disabled");
    a_tmr_clear: assert property ((vel_cap && cren_r) ##1 !tmr_wr |=> tmr_r == '0)
        else $error("timer not cleared after capture");
    a_ic_priority: assert property (on |=> !capture_channel_active)
        else $error("capture channel active with decoder on");

    c_vel_capture: cover property (vel_cap && dec_r == 2'h1);
    c_index_reset: cover property (reset_evt && idx_mode);
    c_dir_change: cover property (dir_chg_r);
    c_period_wrap: cover property (per_mode && cnt_edge && pos_r == max_r);
endmodule
`default_nettype wire

// file: qpv_enc_model.sv
// Behavioural incremental encoder model driving the decoder phase and index lines
`timescale 1ns/1ps
`default_nettype none
module qpv_enc_model (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic step, // Request one quarter step
    input wire logic fwd, // Step direction, 1 forward
    input wire logic index_req, // Wanted index level
    output logic phase_a, // Phase A line
    output logic phase_b, // Phase B line
    output logic index_out, // Index line
    output logic busy // Quarter step still settling
);
    logic [1:0] q_r;
    logic [3:0] gap_r;
    // Gray walk; forward means A rises while B is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= 2'h0;
            gap_r <= 4'h0;
        end else if (step && gap_r == 4'h0) begin
            q_r <= fwd ? q_r + 2'h1 : q_r - 2'h1;
            gap_r <= 4'hB;
        end else if (gap_r != 4'h0) begin
            gap_r <= gap_r - 4'h1;
        end
    end
    // Steps spaced 12 clocks apart keep a full cycle far above the minimum
    assign phase_a = q_r == 2'h1 || q_r == 2'h2;
    assign phase_b = q_r[1];
    assign index_out = index_req;
    assign busy = gap_r != 4'h0;
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the quadrature position and velocity decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_count++; if ((g) !== (e)) begin num_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q, vel;
    logic pready, pslverr, err, phase_a_input, phase_b_input, index_input, busy;
    logic step = 1'b0;
    logic fwd = 1'b1;
    logic idx_req = 1'b0;
    logic position_event_flag, direction_change_flag, velocity_event_flag;
    logic counter_error_bit, capture_channel_active;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    always #25 pclk = ~pclk;
    qpv_decoder qpv_decoder_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .phase_a_input, .phase_b_input,
        .index_input, .position_event_flag, .direction_change_flag,
        .velocity_event_flag, .counter_error_bit, .capture_channel_active);
    qpv_enc_model qpv_enc_model_inst (.pclk, .presetn, .step, .fwd, .index_req(idx_req),
        .phase_a(phase_a_input), .phase_b(phase_b_input), .index_out(index_input), .busy);
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    // Quarter steps of the encoder, each waited out before the next
    task automatic mv(input logic f, input int n);
        int k;
        repeat (n) begin
            fwd <= f;
            step <= 1'b1;
            @(posedge pclk);
            step <= 1'b0;
            @(posedge pclk);
            k = 0;
            while (busy && k < 40) begin
                @(posedge pclk);
                k++;
            end
        end
        repeat (4) @(posedge pclk);
    endtask
    task automatic conclude;
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Hang guard, far above the roughly 1700 cycles the sequence needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        mv(1'b1, 2);
        rd(qpv_pkg::OFS_POS, 32'h0);
        wr(qpv_pkg::OFS_MAX, 32'h5);
        wr(qpv_pkg::OFS_CTRL, 32'h18);
        mv(1'b1, 4);
        rd(qpv_pkg::OFS_POS, 32'h4);
        rd(qpv_pkg::OFS_CTRL, 32'h38);
        mv(1'b1, 2);
        rd(qpv_pkg::OFS_POS, 32'h0);
        `CHK(position_event_flag, 1'b1)
        wr(qpv_pkg::OFS_FLAG, 32'h7);
        mv(1'b0, 1);
        rd(qpv_pkg::OFS_POS, 32'h5);
        `CHK(direction_change_flag, 1'b1)
        wr(qpv_pkg::OFS_MAX, 32'h64);
        wr(qpv_pkg::OFS_POS, 32'h0);
        wr(qpv_pkg::OFS_CTRL, 32'h08);
        mv(1'b1, 4);
        rd(qpv_pkg::OFS_POS, 32'h2);
        wr(qpv_pkg::OFS_CTRL, 32'h200);
        mv(1'b1, 4);
        rd(qpv_pkg::OFS_POS, 32'h2);
        `CHK(capture_channel_active, 1'b1)
        apb(1'b0, 8'h40, 32'h0);
        `CHK(err, 1'b1)
        wr(qpv_pkg::OFS_POS, 32'hA);
        wr(qpv_pkg::OFS_CTRL, 32'h214);
        wr(qpv_pkg::OFS_FLAG, 32'h7);
        idx_req <= 1'b1;
        repeat (6) @(posedge pclk);
        mv(1'b1, 1);
        rd(qpv_pkg::OFS_POS, 32'h0);
        `CHK(position_event_flag, 1'b1)
        `CHK(capture_channel_active, 1'b0)
        mv(1'b0, 1);
        rd(qpv_pkg::OFS_CTRL, 32'h254);
        idx_req <= 1'b0;
        repeat (6) @(posedge pclk);
        mv(1'b0, 1);
        rd(qpv_pkg::OFS_POS, 32'h64);
        `CHK(counter_error_bit, 1'b1)
        wr(qpv_pkg::OFS_CTRL, 32'h14);
        rd(qpv_pkg::OFS_CTRL, 32'h14);
        wr(qpv_pkg::OFS_CTRL, 32'h98);
        wr(qpv_pkg::OFS_FLAG, 32'h7);
        mv(1'b1, 1);
        `CHK(velocity_event_flag, 1'b0)
        // Each ratio in turn; a capture restarts the postscaler at zero
        for (int d = 0; d < 4; d++) begin
            wr(qpv_pkg::OFS_CTRL, 32'h118 | d);
            wr(qpv_pkg::OFS_FLAG, 32'h7);
            mv(1'b1, (1 << (2 * d)) - 1);
            `CHK(velocity_event_flag, 1'b0)
            mv(1'b1, 1);
            `CHK(velocity_event_flag, 1'b1)
        end
        apb(1'b0, qpv_pkg::OFS_VEL, 32'h0);
        vel = q;
        apb(1'b0, qpv_pkg::OFS_TMR, 32'h0);
        `CHK(q < vel, 1'b1)
        // Leaving and re-entering velocity mode leaves the time base counting on
        wr(qpv_pkg::OFS_CTRL, 32'h98);
        wr(qpv_pkg::OFS_TMR, 32'h1000);
        wr(qpv_pkg::OFS_CTRL, 32'h118);
        rd(qpv_pkg::OFS_TMR, 32'h1004);
        // Two-times index mode: count and velocity follow phase A only
        wr(qpv_pkg::OFS_CTRL, 32'h105);
        wr(qpv_pkg::OFS_FLAG, 32'h7);
        mv(1'b1, 6);
        `CHK(velocity_event_flag, 1'b0)
        mv(1'b1, 1);
        `CHK(velocity_event_flag, 1'b1)
        rd(qpv_pkg::OFS_POS, 32'h59);
        idx_req <= 1'b1;
        repeat (6) @(posedge pclk);
        mv(1'b1, 2);
        rd(qpv_pkg::OFS_POS, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
